// file: core/pcrc_pkg.sv
package pcrc_pkg;

	// ==========================================================
	// Widths and field layouts.
	// ==========================================================
	localparam int DATA_W   = 16;             // Data port and feedback register width.
	localparam int LEN_W    = 4;              // Length-minus-one field width.
	localparam int CNT_W    = 5;              // Word count width, holds up to 16.
	localparam int DEPTH_MAX = 16;            // Largest FIFO depth.
	localparam int PTR_W    = 4;              // FIFO pointer width.

	localparam logic [LEN_W-1:0] LEN_DEEP_LIMIT = 4'h7;  // Above this the FIFO is shallow.
	localparam logic [CNT_W-1:0] DEPTH_SHALLOW  = 5'h08; // Depth for long polynomials.
	localparam logic [CNT_W-1:0] DEPTH_DEEP     = 5'h10; // Depth for short polynomials.
	localparam logic [CNT_W-1:0] CNT_ZERO       = 5'h00; // Empty count.
	localparam logic [CNT_W-1:0] CNT_ONE        = 5'h01; // Count step and last-word count.
	localparam logic [LEN_W-1:0] LEN_FULL16     = 4'hF;  // Length code of a 16-bit polynomial.
	localparam logic [LEN_W-1:0] BIT_ZERO       = 4'h0;  // First bit index.

	// Reset values.
	localparam logic [DATA_W-1:0] CRC_RESET   = 16'h0000;
	localparam logic [DATA_W-1:1] TERMS_RESET = 15'h0000;

	// ==========================================================
	// Grouped control and status.
	// ==========================================================
	typedef struct packed {
		logic              shift_run;          // Start the serial shifter; clearing it does not stop a run before empty.
		logic              idle_halt_select;   // Halt in idle when set.
		logic [LEN_W-1:0]  poly_len_minus_one; // Polynomial length minus one.
		logic [DATA_W-1:1] poly_terms;         // Feedback term enables x^1..x^15.
	} pcrc_cfg_s;

	typedef struct packed {
		logic [CNT_W-1:0] fifo_word_count; // Valid words queued.
		logic             fifo_full_flag;  // Count at depth.
		logic             fifo_empty_flag; // Count at zero.
		logic             shifter_busy;    // Shifter is running.
	} pcrc_stat_s;

	typedef enum logic {PCRC_IDLE, PCRC_SHIFT} pcrc_state_e;

endpackage

// file: core/pcrc_core.sv
`timescale 1ns/1ns

// Operation
// - Terms from 15-bit mask, length minus one
// - x^0 always; x^16 always for 16-bit
// - Shifting waits for shift-run set
// - FIFO depth 8 above length 8, else 16
// - Word write increments word count
// - Start only when run and count nonzero
// - Decrement after word LSB; run to zero
// - One bit per clock, length cycles
// - Full flag when count reaches depth
// - Empty flag at zero, set after reset
// - Write when full wraps count, no interrupt
// - Interrupt only on count one to zero
// - Sleep freezes state, resumes later
// - Idle halts when select set, interrupt clears
// - Clearing run stops only after empty
module pcrc_core
(
	// Clock and reset.
	input  wire logic                       clk,
	input  wire logic                       nrst,
	// Configuration.
	input  wire pcrc_pkg::pcrc_cfg_s        cfg,
	// Data port write, one-cycle strobe with its word.
	input  wire logic                       data_wr,
	input  wire logic [pcrc_pkg::DATA_W-1:0] data_in,
	// Power states, levels from the clock controller.
	input  wire logic                       sleep_mode,
	input  wire logic                       idle_mode,
	// Results.
	output logic [pcrc_pkg::DATA_W-1:0]     data_port,
	output pcrc_pkg::pcrc_stat_s            stat,
	output logic                            crc_irq
);

	// ==========================================================
	// Depth selection.
	// ==========================================================
	// Depth follows the programmed length, used by count and pointers.
	function automatic logic [pcrc_pkg::CNT_W-1:0] depth_of(input logic [pcrc_pkg::LEN_W-1:0] len);
		depth_of = (len > pcrc_pkg::LEN_DEEP_LIMIT) ? pcrc_pkg::DEPTH_SHALLOW
			: pcrc_pkg::DEPTH_DEEP;
	endfunction

	// ==========================================================
	// State.
	// ==========================================================
	logic [pcrc_pkg::DATA_W-1:0] fifo_mem [pcrc_pkg::DEPTH_MAX]; // Queued words.
	logic [pcrc_pkg::PTR_W-1:0]  wr_ptr_reg, wr_ptr_next;       // Write pointer.
	logic [pcrc_pkg::PTR_W-1:0]  rd_ptr_reg, rd_ptr_next;       // Read pointer.
	logic [pcrc_pkg::CNT_W-1:0]  count_reg, count_next;         // Word count.
	logic [pcrc_pkg::DATA_W-1:0] crc_reg, crc_next;             // Feedback register.
	logic [pcrc_pkg::LEN_W-1:0]  bit_reg, bit_next;             // Bit index in word.
	pcrc_pkg::pcrc_state_e       state_reg, state_next;         // Shifter state.
	logic                        irq_reg, irq_next;             // Completion pulse.
	logic                        halted;                        // Module clocks gated.
	logic [pcrc_pkg::CNT_W-1:0]  depth;                         // Current depth.
	logic                        full;                          // Count at depth.
	logic                        in_bit;                        // Data bit shifted in.
	logic                        fb;                            // Feedback bit.
	logic [pcrc_pkg::DATA_W-1:0] cur_word;                      // Word being shifted.
	logic                        last_bit;                      // LSB of word reached.
	logic                        shift_en;                      // Shift this cycle.

	// Sleep, or idle with the halt select, freezes every register except the interrupt pulse, which clears.
	assign halted = sleep_mode | (idle_mode & cfg.idle_halt_select);
	assign depth  = depth_of(cfg.poly_len_minus_one);
	assign full   = (count_reg == depth);

	// ==========================================================
	// Shifter and count.
	// ==========================================================
	// Next-state logic for pointers, count, shifter and interrupt.
	always_comb
	begin
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		count_next  = count_reg;
		crc_next    = crc_reg;
		bit_next    = bit_reg;
		state_next  = state_reg;
		irq_next    = 1'b0;
		cur_word    = fifo_mem[rd_ptr_reg];
		// Word bits are taken MSB first, from the programmed top bit down.
		in_bit      = cur_word[pcrc_pkg::LEN_W'(cfg.poly_len_minus_one - bit_reg)];
		fb          = crc_reg[cfg.poly_len_minus_one] ^ in_bit;
		last_bit    = (bit_reg == cfg.poly_len_minus_one);
		shift_en    = 1'b0;
		if (!halted)
		begin
			unique case (state_reg)
				pcrc_pkg::PCRC_IDLE:
				begin
					// Start only once software has set the run bit.
					if (cfg.shift_run && (count_reg != pcrc_pkg::CNT_ZERO))
						state_next = pcrc_pkg::PCRC_SHIFT;
				end
				pcrc_pkg::PCRC_SHIFT:
				begin
					// Keeps running after run clears until empty.
					if (count_reg == pcrc_pkg::CNT_ZERO)
						state_next = pcrc_pkg::PCRC_IDLE;
					else
						shift_en = 1'b1;
				end
			endcase
			if (shift_en)
			begin
				// Galois step: x^0 always, upper terms by mask.
				// Stages above the programmed length are kept clear, so a later,
				// longer polynomial starts from a clean register.
				for (int i = pcrc_pkg::DATA_W - 1; i > 0; i--)
				begin
					crc_next[i] = crc_reg[i-1] ^ (fb & cfg.poly_terms[i]);
					if (i > int'(cfg.poly_len_minus_one))
						crc_next[i] = 1'b0;
				end
				crc_next[0] = fb;
				if (last_bit)
				begin
					bit_next    = pcrc_pkg::BIT_ZERO;
					rd_ptr_next = rd_ptr_reg + 1'b1;
					count_next  = count_reg - pcrc_pkg::CNT_ONE;
					// Only the one-to-zero transition interrupts.
					irq_next    = (count_reg == pcrc_pkg::CNT_ONE) && !data_wr;
				end
				else
					bit_next = bit_reg + 1'b1;
			end
			if (data_wr)
			begin
				if (full)
				begin
					// Overflow wraps to empty, with no interrupt.
					count_next  = pcrc_pkg::CNT_ZERO;
					wr_ptr_next = rd_ptr_reg;
					rd_ptr_next = rd_ptr_reg;
					bit_next    = pcrc_pkg::BIT_ZERO;
					irq_next    = 1'b0;
				end
				else
				begin
					wr_ptr_next = wr_ptr_reg + 1'b1;
					// A write in the same cycle as a retire leaves the count level.
					count_next  = count_next + pcrc_pkg::CNT_ONE;
					if (count_next == pcrc_pkg::CNT_ONE)
						irq_next = 1'b0;
				end
			end
			// A shallow FIFO wraps its pointers at eight entries.
			if (depth == pcrc_pkg::DEPTH_SHALLOW)
			begin
				wr_ptr_next[pcrc_pkg::PTR_W-1] = 1'b0;
				rd_ptr_next[pcrc_pkg::PTR_W-1] = 1'b0;
			end
		end
	end

	// Registers; memory is written outside the reset branch so it maps to RAM.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= pcrc_pkg::CNT_ZERO;
			crc_reg    <= pcrc_pkg::CRC_RESET;
			bit_reg    <= pcrc_pkg::BIT_ZERO;
			state_reg  <= pcrc_pkg::PCRC_IDLE;
			irq_reg    <= 1'b0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
			crc_reg    <= crc_next;
			bit_reg    <= bit_next;
			state_reg  <= state_next;
			irq_reg    <= irq_next;
		end
	end

	// FIFO storage has no reset; only counted entries are ever read.
	always_ff @(posedge clk)
	begin
		if (data_wr && !halted && !full)
			fifo_mem[wr_ptr_reg] <= data_in;
	end

	// ==========================================================
	// Outputs.
	// ==========================================================
	assign data_port                = crc_reg;
	assign stat.fifo_word_count     = count_reg;
	assign stat.fifo_full_flag      = full;
	assign stat.fifo_empty_flag     = (count_reg == pcrc_pkg::CNT_ZERO);
	assign stat.shifter_busy        = (state_reg == pcrc_pkg::PCRC_SHIFT);
	assign crc_irq                  = irq_reg;

	// ==========================================================
	// Checks.
	// ==========================================================
	irq_on_drop_a: assert property (@(posedge clk) disable iff (!nrst)
		crc_irq |-> ($past(count_reg) == pcrc_pkg::CNT_ONE && count_reg == pcrc_pkg::CNT_ZERO))
		else $error("interrupt without count one to zero");
	no_start_a: assert property (@(posedge clk) disable iff (!nrst)
		(state_reg == pcrc_pkg::PCRC_IDLE && !cfg.shift_run)
		|=> (state_reg == pcrc_pkg::PCRC_IDLE && crc_reg == $past(crc_reg)))
		else $error("shifted without run bit");
	halt_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		halted |=> (count_reg == $past(count_reg) && crc_reg == $past(crc_reg)))
		else $error("state moved while halted");
	overflow_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
		(data_wr && full && !halted) |=> (count_reg == pcrc_pkg::CNT_ZERO && !crc_irq))
		else $error("overflow did not wrap");
	write_count_a: assert property (@(posedge clk) disable iff (!nrst)
		(data_wr && !full && !halted && !shift_en) |=> (count_reg == $past(count_reg) + 1'b1))
		else $error("write did not count");
	count_bound_a: assert property (@(posedge clk) disable iff (!nrst)
		count_reg <= depth_of(cfg.poly_len_minus_one) || $changed(cfg.poly_len_minus_one))
		else $error("count above depth");
	run_to_empty_a: assert property (@(posedge clk) disable iff (!nrst)
		(stat.shifter_busy && count_reg != pcrc_pkg::CNT_ZERO && !halted) |=> stat.shifter_busy)
		else $error("shifter stopped early");
	empty_flag_a: assert property (@(posedge clk) disable iff (!nrst)
		(shift_en && last_bit && count_reg == pcrc_pkg::CNT_ONE && !data_wr)
		|=> (stat.fifo_empty_flag && crc_irq))
		else $error("empty flag not set after last word");

endmodule // pcrc_core

// file: dv/pcrc_core_tb_top.sv
`timescale 1ns/1ns

module pcrc_core_tb_top;

	// ==========================================================
	// Bench signals.
	// ==========================================================
	logic                 clk        = 1'b0;     // Bench clock, 100 ns period.
	logic                 nrst       = 1'b0;     // Reset, active low.
	pcrc_pkg::pcrc_cfg_s  cfg        = '0;       // Configuration levels.
	logic                 data_wr    = 1'b0;     // Word write strobe.
	logic [15:0]          data_in    = 16'h0000; // Written word.
	logic                 sleep_mode = 1'b0;     // Sleep level.
	logic                 idle_mode  = 1'b0;     // Idle level.
	logic [15:0]          data_port;             // Result register.
	pcrc_pkg::pcrc_stat_s stat;                  // Count and flags.
	logic                 crc_irq;               // Completion pulse.
	logic [15:0]          crc_exp    = 16'h0000; // Expected result, carried across runs.
	int                   num_errors = 0;
	int                   n_checks   = 0;

	always #50 clk = ~clk;

	pcrc_core uut (.clk(clk), .nrst(nrst), .cfg(cfg), .data_wr(data_wr), .data_in(data_in),
		.sleep_mode(sleep_mode), .idle_mode(idle_mode), .data_port(data_port),
		.stat(stat), .crc_irq(crc_irq));

	// ==========================================================
	// Shared helpers.
	// ==========================================================
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report;
		if (num_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Reference shifter: MSB first, feedback from the top stage into stage 0 and each tap.
	function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] w,
		input int len, input logic [15:1] t);
		logic fb;
		for (int i = len; i >= 0; i--)
		begin
			fb = w[i] ^ c[len];
			c = c << 1;
			c[0] = fb;
			for (int k = 1; k <= len; k++)
				if (t[k])
					c[k] = c[k] ^ fb;
		end
		return c & (16'hFFFF >> (15 - len));
	endfunction

	// Writes are spaced one idle cycle apart, so no strobe is set twice in a step.
	task automatic wr(input logic [15:0] w);
		@(posedge clk);
		data_wr <= 1'b1;
		data_in <= w;
		@(posedge clk);
		data_wr <= 1'b0;
		#1;
	endtask

	task automatic setcfg(input logic run, input logic [3:0] len, input logic [15:1] t);
		@(posedge clk);
		cfg.shift_run          <= run;
		cfg.poly_len_minus_one <= len;
		cfg.poly_terms         <= t;
		#1;
	endtask

	// Bounded wait for a count value; returns the number of edges taken.
	task automatic wait_count(input logic [4:0] target, output int n);
		n = 0;
		while (stat.fifo_word_count !== target)
		begin
			@(posedge clk);
			#1;
			n++;
			if (n > 400)
			begin
				chk("wait bound", 16'h0001, 16'h0000);
				final_report();
			end
		end
	endtask

	// ==========================================================
	// Scenarios.
	// ==========================================================
	task automatic t_reset;
		chk("data_port", data_port, 16'h0000);
		chk("count", 16'(stat.fifo_word_count), 16'h0000);
		chk("empty", 16'(stat.fifo_empty_flag), 16'h0001);
		chk("full", 16'(stat.fifo_full_flag), 16'h0000);
		chk("irq", 16'(crc_irq), 16'h0000);
	endtask

	// Two words queued while stopped, then run; run is dropped early and must still drain.
	task automatic t_calc(input logic [3:0] len, input logic [15:1] t, input logic [15:0] w0,
		input logic [15:0] w1);
		int n;
		setcfg(1'b0, len, t);
		wr(w0);
		wr(w1);
		@(posedge clk);
		#1;
		chk("count two", 16'(stat.fifo_word_count), 16'h0002);
		repeat (20) @(posedge clk);
		#1;
		chk("idle hold", 16'(stat.fifo_word_count), 16'h0002);
		chk("busy off", 16'(stat.shifter_busy), 16'h0000);
		setcfg(1'b1, len, t);
		wait_count(5'h01, n);
		chk("irq at two to one", 16'(crc_irq), 16'h0000);
		setcfg(1'b0, len, t);
		wait_count(5'h00, n);
		chk("cycles per word", 16'(n + 1), 16'(len) + 16'h0001);
		chk("irq at one to zero", 16'(crc_irq), 16'h0001);
		chk("empty", 16'(stat.fifo_empty_flag), 16'h0001);
		crc_exp = crc_word(crc_word(crc_exp, w0, len, t), w1, len, t);
		chk("result", data_port, crc_exp);
		@(posedge clk);
		#1;
		chk("irq one cycle", 16'(crc_irq), 16'h0000);
	endtask

	task automatic t_full(input logic [3:0] len, input logic [4:0] depth);
		setcfg(1'b0, len, 15'h0000);
		for (int i = 1; i < depth; i++)
			wr(16'(i));
		chk("not full", 16'(stat.fifo_full_flag), 16'h0000);
		wr(16'h00FF);
		chk("full", 16'(stat.fifo_full_flag), 16'h0001);
		chk("count at depth", 16'(stat.fifo_word_count), 16'(depth));
		wr(16'h00AA);
		chk("wrap count", 16'(stat.fifo_word_count), 16'h0000);
		chk("wrap empty", 16'(stat.fifo_empty_flag), 16'h0001);
		chk("wrap irq", 16'(crc_irq), 16'h0000);
		@(posedge clk);
		#1;
		chk("wrap irq late", 16'(crc_irq), 16'h0000);
	endtask

	task automatic t_power;
		int n;
		setcfg(1'b0, 4'h7, 15'h0003);
		wr(16'h005A);
		@(posedge clk);
		sleep_mode       <= 1'b1;
		cfg.shift_run    <= 1'b1;
		repeat (20) @(posedge clk);
		#1;
		chk("sleep hold", 16'(stat.fifo_word_count), 16'h0001);
		@(posedge clk);
		sleep_mode           <= 1'b0;
		idle_mode            <= 1'b1;
		cfg.idle_halt_select <= 1'b1;
		repeat (20) @(posedge clk);
		#1;
		chk("idle halt", 16'(stat.fifo_word_count), 16'h0001);
		@(posedge clk);
		cfg.idle_halt_select <= 1'b0;
		wait_count(5'h00, n);
		chk("idle run irq", 16'(crc_irq), 16'h0001);
		crc_exp = crc_word(crc_exp, 16'h005A, 7, 15'h0003);
		chk("resumed result", data_port, crc_exp);
		@(posedge clk);
		idle_mode <= 1'b0;
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		#1;
		t_reset();
		t_calc(4'h7, 15'h0003, 16'hFF3C, 16'hA5C1);
		t_calc(4'hF, 15'h0810, 16'hA5C3, 16'h1234);
		t_full(4'hF, 5'h08);
		t_full(4'h7, 5'h10);
		t_power();
		final_report();
	end

endmodule // pcrc_core_tb_top
